/* File: shared/rtcisi_pkg.sv */
package rtcisi_pkg;
	// Bus constants
	localparam logic [6:0] DEV_ADDR = 7'h68;
	localparam logic DIR_READ = 1'h1;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [7:0] PTR_RESET = 8'h00;

	// Timing of the master's clock divider, in quarter periods of SCL
	localparam int CLK_HZ = 50_000_000;
	localparam int STD_HZ = 100_000;
	localparam int FAST_HZ = 400_000;
	localparam int QTR_STD_CYC = (CLK_HZ + 4 * STD_HZ - 1) / (4 * STD_HZ);
	localparam int QTR_FAST_CYC = (CLK_HZ + 4 * FAST_HZ - 1) / (4 * FAST_HZ);
	localparam logic [7:0] QTR_STD = 8'(QTR_STD_CYC - 1);
	localparam logic [7:0] QTR_FAST = 8'(QTR_FAST_CYC - 1);

	// Master commands
	typedef enum logic [1:0] {
		CMD_START = 2'h0,
		CMD_WRITE = 2'h1,
		CMD_READ = 2'h2,
		CMD_STOP = 2'h3
	} rtcisi_cmd_type;

	// Meaning of the byte the device is receiving
	typedef enum logic [1:0] {
		KIND_ADDR = 2'h0,
		KIND_PTR = 2'h1,
		KIND_DATA = 2'h2
	} rtcisi_kind_type;

	typedef enum logic [4:0] {
		DS_IDLE = 5'h01,
		DS_RX = 5'h02,
		DS_ACK = 5'h04,
		DS_TX = 5'h08,
		DS_MACK = 5'h10
	} rtcisi_dstate_type;

	typedef enum logic [3:0] {
		MS_IDLE = 4'h1,
		MS_START = 4'h2,
		MS_BIT = 4'h4,
		MS_STOP = 4'h8
	} rtcisi_mstate_type;

	// Device state; line pairs are {scl, sda}
	typedef struct packed {
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [1:0] prev;
		rtcisi_dstate_type state;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		rtcisi_kind_type kind;
		logic rw;
		logic macked;
		logic [7:0] ptr;
		logic sda_oe;
		logic wr_stb;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
	} rtcisi_dev_type;

	localparam rtcisi_dev_type DEV_RESET = '{
		sync1: 2'h3, sync2: 2'h3, prev: 2'h3, state: DS_IDLE, bitcnt: 4'h0,
		shreg: 8'h00, kind: KIND_ADDR, rw: 1'h0, macked: 1'h0, ptr: PTR_RESET,
		sda_oe: 1'h0, wr_stb: 1'h0, wr_addr: 8'h00, wr_data: 8'h00};

	typedef struct packed {
		logic sda_s1;
		logic sda_s2;
		rtcisi_mstate_type state;
		logic [7:0] qcnt;
		logic [1:0] phase;
		logic [3:0] bitn;
		logic [7:0] shreg;
		logic is_read;
		logic nack;
		logic scl_oe;
		logic sda_oe;
		logic ready;
		logic done;
		logic ack;
		logic [7:0] rd_data;
	} rtcisi_mst_type;

	localparam rtcisi_mst_type MST_RESET = '{
		sda_s1: 1'h1, sda_s2: 1'h1, state: MS_IDLE, qcnt: 8'h00, phase: 2'h0,
		bitn: 4'h0, shreg: 8'h00, is_read: 1'h0, nack: 1'h0, scl_oe: 1'h0,
		sda_oe: 1'h0, ready: 1'h1, done: 1'h0, ack: 1'h0, rd_data: 8'h00};
endpackage

/* File: shared/rtcisi_bus_if.sv */
`timescale 1ns/1ps
// Open-drain two-wire bus; a line is low while any party enables its driver
interface rtcisi_bus_if;
	logic m_scl_oe;
	logic m_sda_oe;
	logic d_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND resolution with pull-ups
	assign scl = ~m_scl_oe;
	assign sda = ~(m_sda_oe | d_sda_oe);

	modport master (output m_scl_oe, output m_sda_oe, input scl, input sda);
	modport device (output d_sda_oe, input scl, input sda);
endinterface

/* File: rtl/rtcisi_device.sv */
`timescale 1ns/1ps
module rtcisi_device (
	// Link-side sampling clock and reset
	input wire logic i_link_clk,
	input wire logic i_nrst,
	// Two-wire bus
	rtcisi_bus_if.device bus,
	// Register file port, on i_link_clk
	output logic o_wr_stb,
	output logic [7:0] o_wr_addr,
	output logic [7:0] o_wr_data,
	output logic [7:0] o_rd_addr,
	input wire logic [7:0] i_rd_data
);
	import rtcisi_pkg::*;

	// The port listens to both lines and drives only the data line; it never drives the clock line.
	// Line samples pass two flip-flops, then a third copy gives the previous
	// sample, so every edge is seen three link clocks after it happens.
	// A bus clock quarter lasts hundreds of nanoseconds even at the fast rate,
	// so that lag stays well inside the low half of each clock period.
	//
	// Receive walk, one byte:
	//   eight rising clock edges shift the data line in, oldest bit on top;
	//   at the eighth falling edge the byte is judged by its kind:
	//     address - compare the top seven bits, keep the direction bit;
	//     pointer - load the register pointer;
	//     data    - pulse the write strobe at the pointer, then advance it;
	//   the acknowledge pull starts then and ends after the ninth falling edge.
	//
	// Transmit walk, one byte:
	//   the first bit goes out after the falling edge that closes the
	//   acknowledge pulse, each further bit after the next falling edge;
	//   after the eighth bit the line is released and the pointer advances,
	//   before the master answers, so a refused byte still moves it on;
	//   the master's answer is sampled at the ninth rising edge;
	//   an acknowledge reloads the shifter from the read port at the
	//   ninth falling edge, a refusal sends the port back to idle.
	//
	// Hazards and limits:
	//   the read port is combinational from the pointer, so the shifter
	//   is loaded at least one clock after the pointer moves, never in it;
	//   a START or STOP aborts a partial byte with no write and no ack,
	//   and the pointer keeps whatever it last held;
	//   glitches shorter than one link clock are not filtered;
	//   a mismatched address leaves the port deaf until the next START;
	//   the clock line is never stretched, so the register file behind
	//   the port must answer within one bus clock period of a pointer change;
	//   the pointer is eight bits wide and wraps from the top to zero,
	//   which lets a long burst run round the whole map without a stop.
	//
	// Trade-off: sampling on a free-running link clock costs three clocks
	// of lag but keeps every register on one clock, with no logic clocked
	// by the bus line itself.

	// Open drain: a one on the wire is a release, a zero is a pull
	function automatic logic pull_for(input logic bit_val);
		pull_for = ~bit_val;
	endfunction

	// Pointer step, wrapping from the top register to zero
	function automatic logic [7:0] ptr_step(input logic [7:0] ptr_val);
		ptr_step = ptr_val + 8'h01;
	endfunction

	// Registered state and its next value
	rtcisi_dev_type r;
	rtcisi_dev_type next_r;
	// Line events decoded from the delayed samples
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	// Edges are taken between the second sync stage and its delayed copy only
	assign scl_rise = r.sync2[1] & ~r.prev[1];
	assign scl_fall = ~r.sync2[1] & r.prev[1];
	assign start_seen = r.sync2[1] & r.prev[1] & r.prev[0] & ~r.sync2[0];
	assign stop_seen = r.sync2[1] & r.prev[1] & ~r.prev[0] & r.sync2[0];

	// Next-state logic
	always_comb begin
		next_r = r;
		// Oversampling keeps dozens of samples per bit even at the fast rate
		next_r.sync1 = {bus.scl, bus.sda};
		next_r.sync2 = r.sync1;
		next_r.prev = r.sync2;
		next_r.wr_stb = 1'h0;
		if (start_seen) begin
			// A START anywhere aborts the byte; the pointer is left alone
			next_r.state = DS_RX;
			next_r.bitcnt = 4'h0;
			next_r.kind = KIND_ADDR;
			next_r.sda_oe = 1'h0;
		end else if (stop_seen) begin
			next_r.state = DS_IDLE;
			next_r.sda_oe = 1'h0;
		end else begin
			unique case (r.state)
				// Waiting for START with the data line released
				DS_IDLE: begin
					next_r.sda_oe = 1'h0;
				end
				// Shifting in a byte from the master
				DS_RX: begin
					if (scl_rise) begin
						// Sample while SCL is high, MSB arrives first
						next_r.shreg = {r.shreg[6:0], r.sync2[0]};
						next_r.bitcnt = r.bitcnt + 4'h1;
					end else if (scl_fall && r.bitcnt == BYTE_BITS) begin
						unique case (r.kind)
							KIND_ADDR: begin
								if (r.shreg[7:1] == DEV_ADDR) begin
									next_r.rw = r.shreg[0];
									next_r.sda_oe = 1'h1;
									next_r.state = DS_ACK;
								end else begin
									next_r.state = DS_IDLE;
								end
							end
							KIND_PTR: begin
								next_r.ptr = r.shreg;
								next_r.sda_oe = 1'h1;
								next_r.state = DS_ACK;
							end
							default: begin
								next_r.wr_stb = 1'h1;
								next_r.wr_addr = r.ptr;
								next_r.wr_data = r.shreg;
								next_r.ptr = ptr_step(r.ptr);
								next_r.sda_oe = 1'h1;
								next_r.state = DS_ACK;
							end
						endcase
					end
				end
				// Acknowledge pulse driven by the port
				DS_ACK: begin
					// Held low across the whole ack pulse; after its fall released, or set to the first data bit for a read
					if (scl_fall) begin
						next_r.sda_oe = 1'h0;
						next_r.bitcnt = 4'h0;
						if (r.kind == KIND_ADDR && r.rw == DIR_READ) begin
							next_r.shreg = i_rd_data;
							next_r.sda_oe = pull_for(i_rd_data[7]);
							next_r.state = DS_TX;
						end else begin
							next_r.kind = (r.kind == KIND_ADDR) ? KIND_PTR : KIND_DATA;
							next_r.state = DS_RX;
						end
					end
				end
				// Shifting a byte out to the master
				DS_TX: begin
					// New bit goes out just after SCL falls
					if (scl_fall) begin
						next_r.bitcnt = r.bitcnt + 4'h1;
						next_r.shreg = {r.shreg[6:0], 1'h0};
						if (r.bitcnt == LAST_DATA_BIT) begin
							next_r.sda_oe = 1'h0;
							next_r.ptr = ptr_step(r.ptr);
							next_r.state = DS_MACK;
						end else begin
							next_r.sda_oe = pull_for(r.shreg[6]);
						end
					end
				end
				// Master's answer to a transmitted byte
				DS_MACK: begin
					if (scl_rise) begin
						next_r.macked = ~r.sync2[0];
					end else if (scl_fall) begin
						if (r.macked) begin
							// Pointer moved at the eighth falling edge, a whole bus clock ago, so read data is settled
							next_r.shreg = i_rd_data;
							next_r.sda_oe = pull_for(i_rd_data[7]);
							next_r.bitcnt = 4'h0;
							next_r.state = DS_TX;
						end else begin
							next_r.sda_oe = 1'h0;
							next_r.state = DS_IDLE;
						end
					end
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge i_link_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			r <= DEV_RESET;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from state
	assign bus.d_sda_oe = r.sda_oe;
	assign o_wr_stb = r.wr_stb;
	assign o_wr_addr = r.wr_addr;
	assign o_wr_data = r.wr_data;
	assign o_rd_addr = r.ptr;
endmodule

/* File: rtl/rtcisi_master.sv */
`timescale 1ns/1ps
module rtcisi_master (
	// System clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Two-wire bus
	rtcisi_bus_if.master bus,
	// Command port
	input wire logic i_fast,
	input wire logic i_cmd_valid,
	input wire rtcisi_pkg::rtcisi_cmd_type i_cmd,
	input wire logic [7:0] i_data,
	input wire logic i_nack,
	output logic o_ready,
	output logic o_done,
	output logic o_ack,
	output logic [7:0] o_rd_data
);
	import rtcisi_pkg::*;

	rtcisi_mst_type r;
	rtcisi_mst_type next_r;
	logic tick;
	logic [7:0] reload;

	assign tick = (r.qcnt == 8'h00);
	assign reload = i_fast ? QTR_FAST : QTR_STD;

	// Each action is four quarter periods; SDA moves in quarter 0, SCL low, and also in quarter 2, SCL high, for START and STOP
	always_comb begin
		next_r = r;
		next_r.sda_s1 = bus.sda;
		next_r.sda_s2 = r.sda_s1;
		next_r.done = 1'h0;
		if (r.state != MS_IDLE) begin
			next_r.qcnt = tick ? reload : r.qcnt - 8'h01;
			if (tick) begin
				next_r.phase = r.phase + 2'h1;
			end
		end
		unique case (r.state)
			MS_IDLE: begin
				if (i_cmd_valid) begin
					// No busy check: START is only issued by the user on an idle bus or as a repeated start
					next_r.ready = 1'h0;
					next_r.phase = 2'h0;
					next_r.qcnt = reload;
					next_r.bitn = 4'h0;
					next_r.shreg = i_data;
					next_r.is_read = (i_cmd == CMD_READ);
					next_r.nack = i_nack;
					unique case (i_cmd)
						CMD_START: next_r.state = MS_START;
						CMD_STOP: next_r.state = MS_STOP;
						default: next_r.state = MS_BIT;
					endcase
				end
			end
			MS_START: begin
				if (tick) begin
					unique case (r.phase)
						2'h0: next_r.sda_oe = 1'h0;
						2'h1: next_r.scl_oe = 1'h0;
						2'h2: next_r.sda_oe = 1'h1;
						default: begin
							next_r.scl_oe = 1'h1;
							next_r.state = MS_IDLE;
							next_r.ready = 1'h1;
							next_r.done = 1'h1;
						end
					endcase
				end
			end
			MS_STOP: begin
				if (tick) begin
					unique case (r.phase)
						2'h0: next_r.sda_oe = 1'h1;
						2'h1: next_r.scl_oe = 1'h0;
						2'h2: next_r.sda_oe = 1'h0;
						default: begin
							next_r.state = MS_IDLE;
							next_r.ready = 1'h1;
							next_r.done = 1'h1;
						end
					endcase
				end
			end
			MS_BIT: begin
				if (tick) begin
					unique case (r.phase)
						2'h0: begin
							if (r.bitn == BYTE_BITS) begin
								next_r.sda_oe = r.is_read & ~r.nack;
							end else begin
								next_r.sda_oe = ~r.is_read & ~r.shreg[7];
							end
						end
						2'h1: next_r.scl_oe = 1'h0;
						2'h2: begin
							// Sampled mid-way through the high period, well clear of edges
							if (r.bitn == BYTE_BITS) begin
								next_r.ack = ~r.sda_s2;
							end else begin
								next_r.shreg = {r.shreg[6:0], r.sda_s2};
							end
						end
						default: begin
							next_r.scl_oe = 1'h1;
							if (r.bitn == BYTE_BITS) begin
								// Ninth pulse done, byte complete
								next_r.state = MS_IDLE;
								next_r.ready = 1'h1;
								next_r.done = 1'h1;
								next_r.rd_data = r.shreg;
							end else begin
								next_r.bitn = r.bitn + 4'h1;
							end
						end
					endcase
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			r <= MST_RESET;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from state
	assign bus.m_scl_oe = r.scl_oe;
	assign bus.m_sda_oe = r.sda_oe;
	assign o_ready = r.ready;
	assign o_done = r.done;
	assign o_ack = r.ack;
	assign o_rd_data = r.rd_data;
endmodule

/* File: bench/rtcisi_bus_asserts.sv */
`timescale 1ns/1ps
module rtcisi_bus_asserts
	import rtcisi_pkg::*;
(
	// Sampling clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Bus signals
	input wire logic m_scl_oe,
	input wire logic m_sda_oe,
	input wire logic d_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic ps, pd, first, rise, start, stop, match;
	logic [3:0] nbit;
	logic [7:0] addr;

	// Line events; the system clock oversamples SCL many times over
	assign rise = scl & ~ps;
	assign start = scl & ps & pd & ~sda;
	assign stop = scl & ps & ~pd & sda;
	assign match = (addr[7:1] == DEV_ADDR);

	// Pulse count within a byte and the address byte seen after START
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ps <= 1'b1;
			pd <= 1'b1;
			first <= 1'b0;
			nbit <= 4'h0;
			addr <= 8'h00;
		end else begin
			ps <= scl;
			pd <= sda;
			if (start) begin
				first <= 1'b1;
				nbit <= 4'h0;
			end else if (rise) begin
				nbit <= (nbit == 4'h9) ? 4'h1 : nbit + 4'h1;
				if (nbit == 4'h9)
					first <= 1'b0;
				if (first && nbit < 4'h8)
					addr <= {addr[6:0], sda};
			end
		end
	end

	// Ninth clock pulse of a byte
	sequence s_ack_slot;
		rise && nbit == 4'h8;
	endsequence

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	chk_addr_ack: assert property (s_ack_slot ##0 (first && match) |-> d_sda_oe)
		else $error("address acknowledge missing");
	chk_write_ack: assert property (s_ack_slot ##0 (!first && match && !addr[0]) |-> d_sda_oe && !m_sda_oe)
		else $error("write byte acknowledge missing");
	chk_read_release: assert property (s_ack_slot ##0 (!first && match && addr[0]) |-> !d_sda_oe)
		else $error("device holds data line in master ack slot");
	chk_miss_silent: assert property (!match && (!first || nbit >= 4'h8) |-> !d_sda_oe)
		else $error("device drives after address mismatch");
	chk_addr_quiet: assert property (first && nbit < 4'h8 |-> !d_sda_oe)
		else $error("device drives during address byte");
	chk_sda_stable: assert property (scl && ps |-> $stable(d_sda_oe))
		else $error("device changed data line while clock high");
	chk_stop_idle: assert property (stop |-> (sda && !m_scl_oe)[*8])
		else $error("bus not idle after stop");
	chk_start_clock: assert property (start |-> ##[1:130] !scl)
		else $error("clock did not fall after start");
	chk_stop_release: assert property (stop |-> (!d_sda_oe)[*8])
		else $error("device drives data line after stop");
endmodule

/* File: bench/rtc_i2c_slave_interface_tb_top.sv */
`timescale 1ns/1ps
module rtc_i2c_slave_interface_tb_top;
	import rtcisi_pkg::*;
	logic i_clk = 0, link_clk = 0, i_nrst = 0;
	logic i_fast = 0, i_cmd_valid = 0, i_nack = 0;
	rtcisi_cmd_type i_cmd = CMD_START;
	logic [7:0] i_data = 8'h00, o_rd_data, o_wr_addr, o_wr_data, o_rd_addr;
	logic o_ready, o_done, o_ack, o_wr_stb;
	logic [8:0] mon = 9'h000;
	logic [7:0] regs [256];
	// Rows: rate, pointer, byte written and read back
	logic [16:0] rows [3] = '{17'h000a5, 17'h10e3c, 17'h1ff81};
	int err_total = 0, checks = 0, r;
	rtcisi_bus_if bus();

	// Clocks; the link period is no multiple of the system period
	always #10 i_clk = ~i_clk;
	always #24 link_clk = ~link_clk;

	rtcisi_master u_rtcisi_master (.i_clk(i_clk), .i_nrst(i_nrst), .bus(bus.master), .i_fast(i_fast),
		.i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_data(i_data), .i_nack(i_nack), .o_ready(o_ready),
		.o_done(o_done), .o_ack(o_ack), .o_rd_data(o_rd_data));
	rtcisi_device u_rtcisi_device (.i_link_clk(link_clk), .i_nrst(i_nrst), .bus(bus.device),
		.o_wr_stb(o_wr_stb), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_rd_addr(o_rd_addr),
		.i_rd_data(regs[o_rd_addr]));
	rtcisi_bus_asserts u_rtcisi_bus_asserts (.i_clk(i_clk), .i_nrst(i_nrst), .m_scl_oe(bus.m_scl_oe),
		.m_sda_oe(bus.m_sda_oe), .d_sda_oe(bus.d_sda_oe), .scl(bus.scl), .sda(bus.sda));

	// Register file behind the device, and the last nine bits seen on the wire
	always @(posedge link_clk) if (o_wr_stb === 1'b1) regs[o_wr_addr] <= o_wr_data;
	always @(posedge bus.scl) mon <= {mon[7:0], bus.sda};

	task summarize;
		begin
			$display("checks %0d errors %0d", checks, err_total);
			if (err_total == 0 && checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask

	task cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
		begin
			checks++;
			if (g !== e) begin
				err_total++;
				$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			end
		end
	endtask

	task cmp1(input string n, input logic e, input logic g);
		begin
			checks++;
			if (g !== e) begin
				err_total++;
				$display("CHECK FAILED %s expected %b seen %b", n, e, g);
			end
		end
	endtask

	// One command; ready is high here, so the request is taken at the second edge
	task cmd(input rtcisi_cmd_type c, input logic [7:0] d, input logic n);
		int k;
		begin
			@(posedge i_clk);
			i_cmd_valid <= 1'b1;
			i_cmd <= c;
			i_data <= d;
			i_nack <= n;
			@(posedge i_clk);
			i_cmd_valid <= 1'b0;
			for (k = 0; k < 5000 && o_done !== 1'b1; k++) @(negedge i_clk);
			if (k == 5000) begin
				err_total++;
				summarize();
			end
		end
	endtask

	task wbyte(input logic [7:0] d, input logic a);
		begin
			cmd(CMD_WRITE, d, 1'b0);
			cmp1("ack", a, o_ack);
			cmp8("wire byte", d, mon[8:1]);
		end
	endtask

	task rbyte(input logic [7:0] e, input logic n);
		begin
			cmd(CMD_READ, 8'h00, n);
			cmp8("read data", e, o_rd_data);
			cmp8("wire byte", e, mon[8:1]);
			cmp1("master ack", n, mon[0]);
		end
	endtask

	// Load the pointer, then turn round into a read by repeated start
	task point(input logic [7:0] p);
		begin
			cmd(CMD_START, 8'h00, 1'b0);
			wbyte(8'hd0, 1'b1);
			wbyte(p, 1'b1);
			cmd(CMD_START, 8'h00, 1'b0);
			wbyte(8'hd1, 1'b1);
		end
	endtask

	initial begin
		for (r = 0; r < 256; r++) regs[r] = 8'(r) ^ 8'h5a;
		repeat (2) @(posedge i_clk);
		i_nrst <= 1'b1;
		@(negedge i_clk);
		cmp1("ready", 1'b1, o_ready);
		cmp8("pointer", PTR_RESET, o_rd_addr);
		for (r = 0; r < 3; r++) begin
			@(posedge i_clk);
			i_fast <= rows[r][16];
			cmd(CMD_START, 8'h00, 1'b0);
			wbyte(8'hd0, 1'b1);
			wbyte(rows[r][15:8], 1'b1);
			wbyte(rows[r][7:0], 1'b1);
			point(rows[r][15:8]);
			rbyte(rows[r][7:0], 1'b1);
			cmd(CMD_STOP, 8'h00, 1'b0);
		end
		// Burst across the pointer wrap, read back in one transfer
		cmd(CMD_START, 8'h00, 1'b0);
		wbyte(8'hd0, 1'b1);
		wbyte(8'hfe, 1'b1);
		wbyte(8'h11, 1'b1);
		wbyte(8'h22, 1'b1);
		wbyte(8'h33, 1'b1);
		point(8'hfe);
		rbyte(8'h11, 1'b0);
		rbyte(8'h22, 1'b0);
		rbyte(8'h33, 1'b1);
		cmd(CMD_STOP, 8'h00, 1'b0);
		// Read from the current pointer with no pointer write
		cmd(CMD_START, 8'h00, 1'b0);
		wbyte(8'hd1, 1'b1);
		rbyte(8'h5b, 1'b1);
		cmd(CMD_STOP, 8'h00, 1'b0);
		// Foreign address: no ack, no write, pointer untouched
		cmd(CMD_START, 8'h00, 1'b0);
		wbyte(8'hd2, 1'b0);
		wbyte(8'h77, 1'b0);
		cmd(CMD_STOP, 8'h00, 1'b0);
		cmd(CMD_START, 8'h00, 1'b0);
		wbyte(8'hd1, 1'b1);
		rbyte(8'h58, 1'b1);
		cmd(CMD_STOP, 8'h00, 1'b0);
		summarize();
	end
endmodule
